// file: socket_force_pkg.sv
// Constants for the socket force event register block
package socket_force_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] EVENT_OFFSET = 8'h00;
	localparam logic [7:0] MASK_OFFSET = 8'h04;
	localparam logic [7:0] PRESENT_OFFSET = 8'h08;
	localparam logic [7:0] FORCE_OFFSET = 8'h0C;
	localparam logic [7:0] POWER_CTRL_OFFSET = 8'h10;
	localparam int ADDR_DECODE_BITS = 8;

	// ----------------------------------------
	// Force register field positions
	// ----------------------------------------
	localparam int REINTERROGATE_BIT = 14;
	localparam int LOWEST_VOLT_BIT = 13;
	localparam int LOW_VOLT_BIT = 12;
	localparam int THREE_VOLT_BIT = 11;
	localparam int FIVE_VOLT_BIT = 10;
	localparam int INVALID_SUPPLY_BIT = 9;
	localparam int DATA_LOSS_BIT = 8;
	localparam int UNRECOGNIZED_BIT = 7;
	localparam int READY_PIN_BIT = 6;
	localparam int WIDE_BUS_BIT = 5;
	localparam int NARROW_BIT = 4;
	localparam int POWER_EVENT_BIT = 3;
	localparam int DETECT_B_BIT = 2;
	localparam int DETECT_A_BIT = 1;
	localparam int STATUS_CHANGE_BIT = 0;

	// ----------------------------------------
	// Present-state socket capability positions
	// ----------------------------------------
	localparam int SOCKET_THREE_VOLT_BIT = 29;
	localparam int SOCKET_FIVE_VOLT_BIT = 28;

	// ----------------------------------------
	// Widths, reset values and the force register read value
	// ----------------------------------------
	localparam int EVENT_WIDTH = 4;
	localparam logic [3:0] EVENT_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [3:0] CAP_RESET = 4'h0;
	localparam logic POWER_CTRL_EN_RESET = 1'b1;
	localparam logic [31:0] FORCE_READ_VALUE = 32'h00000000;

endpackage

// file: event_flag_bank.sv
// Sticky socket event flags with hardware set, forced load and write-one clear
`timescale 1ns/100ps
module event_flag_bank #(
	parameter int WIDTH = 4
) (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [WIDTH-1:0] hw_set_in,
	input wire logic force_we_in,
	input wire logic [WIDTH-1:0] force_data_in,
	input wire logic clear_we_in,
	input wire logic [WIDTH-1:0] clear_data_in,
	output logic [WIDTH-1:0] flags_out
);

	// ----------------------------------------
	// One flag per bit
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			always_ff @(posedge core_clk_in) begin
				if (srst_in) begin
					flags_out[i] <= 1'b0;
				end else if (hw_set_in[i]) begin
					// Hardware set wins over any clear
					flags_out[i] <= 1'b1;
				end else if (force_we_in) begin
					// Forced load of written value
					flags_out[i] <= force_data_in[i];
				end else if (clear_we_in && clear_data_in[i]) begin
					flags_out[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule

// file: socket_force_event_reg.sv
// Socket force event register with APB access to socket event and state
`timescale 1ns/100ps
module socket_force_event_reg (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [3:0] card_volt_cap_in,
	input wire logic wide_bus_card_in,
	input wire logic narrow_card_in,
	input wire logic unrecognized_card_in,
	input wire logic invalid_supply_set_in,
	input wire logic data_loss_set_in,
	input wire logic [3:0] event_set_in,
	input wire logic socket_powered_in,
	input wire logic detect_b_in,
	input wire logic detect_a_in,
	input wire logic status_change_pin_in,
	input wire logic ready_pin_in,
	output logic reinterrogate_trigger_out,
	output logic power_ctrl_enable_out,
	output logic irq_out
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rdata_d;
	logic mapped_d;
	logic access_d;
	logic wr_d;
	logic [7:0] offset_d;
	logic force_we_d;
	logic event_we_d;
	logic [31:0] wmask_d;
	logic [31:0] wdata_d;
	logic [3:0] event_flags_q;
	logic [3:0] mask_q;
	logic [3:0] volt_cap_q;
	logic invalid_supply_q;
	logic data_loss_q;
	logic unrecognized_q;
	logic wide_bus_q;
	logic narrow_q;
	logic [4:0] live_q;
	logic power_ctrl_en_q;
	logic reinterrogate_q;
	logic irq_q;
	logic trigger_d;
	logic volt_forced_one_d;
	logic [31:0] present_d;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign offset_d = paddr_in[socket_force_pkg::ADDR_DECODE_BITS-1:0];
	assign access_d = psel_in && penable_in && !pready_q;
	assign wr_d = psel_in && penable_in && pready_q && pwrite_in && !pslverr_q;
	assign force_we_d = wr_d && (offset_d == socket_force_pkg::FORCE_OFFSET);
	assign event_we_d = wr_d && (offset_d == socket_force_pkg::EVENT_OFFSET);
	assign wmask_d = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
	assign wdata_d = pwdata_in & wmask_d;
	assign trigger_d = force_we_d && wdata_d[socket_force_pkg::REINTERROGATE_BIT];
	assign volt_forced_one_d = force_we_d &&
		(|wdata_d[socket_force_pkg::LOWEST_VOLT_BIT:socket_force_pkg::FIVE_VOLT_BIT]);

	always_comb begin
		mapped_d = (paddr_in[31:socket_force_pkg::ADDR_DECODE_BITS] == '0) && (paddr_in[1:0] == 2'h0);
		if (mapped_d) begin
			unique case (offset_d)
				socket_force_pkg::EVENT_OFFSET,
				socket_force_pkg::MASK_OFFSET,
				socket_force_pkg::PRESENT_OFFSET,
				socket_force_pkg::FORCE_OFFSET,
				socket_force_pkg::POWER_CTRL_OFFSET: mapped_d = 1'b1;
				default: mapped_d = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Present state assembly
	// ----------------------------------------
	always_comb begin
		present_d = 32'h00000000;
		present_d[socket_force_pkg::SOCKET_THREE_VOLT_BIT] = 1'b1;
		present_d[socket_force_pkg::SOCKET_FIVE_VOLT_BIT] = 1'b1;
		present_d[socket_force_pkg::LOWEST_VOLT_BIT:socket_force_pkg::FIVE_VOLT_BIT] = volt_cap_q;
		present_d[socket_force_pkg::INVALID_SUPPLY_BIT] = invalid_supply_q;
		present_d[socket_force_pkg::DATA_LOSS_BIT] = data_loss_q;
		present_d[socket_force_pkg::UNRECOGNIZED_BIT] = unrecognized_q;
		present_d[socket_force_pkg::READY_PIN_BIT] = live_q[4];
		present_d[socket_force_pkg::WIDE_BUS_BIT] = wide_bus_q;
		present_d[socket_force_pkg::NARROW_BIT] = narrow_q;
		present_d[socket_force_pkg::POWER_EVENT_BIT:socket_force_pkg::STATUS_CHANGE_BIT] = live_q[3:0];
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rdata_d = 32'h00000000;
		unique case (offset_d)
			socket_force_pkg::EVENT_OFFSET: rdata_d[3:0] = event_flags_q;
			socket_force_pkg::MASK_OFFSET: rdata_d[3:0] = mask_q;
			socket_force_pkg::PRESENT_OFFSET: rdata_d = present_d;
			socket_force_pkg::FORCE_OFFSET: rdata_d = socket_force_pkg::FORCE_READ_VALUE;
			socket_force_pkg::POWER_CTRL_OFFSET: rdata_d[0] = power_ctrl_en_q;
			default: rdata_d = 32'h00000000;
		endcase
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= access_d;
			pslverr_q <= access_d && !mapped_d;
			if (access_d && !pwrite_in && mapped_d) begin
				prdata_q <= rdata_d;
			end else if (access_d) begin
				prdata_q <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Socket event flags
	// ----------------------------------------
	event_flag_bank #(
		.WIDTH(socket_force_pkg::EVENT_WIDTH)
	) u_event_flags (
		.core_clk_in(core_clk_in),
		.srst_in(srst_in),
		.hw_set_in(event_set_in),
		.force_we_in(force_we_d && pstrb_in[0]),
		.force_data_in(pwdata_in[socket_force_pkg::POWER_EVENT_BIT:socket_force_pkg::STATUS_CHANGE_BIT]),
		.clear_we_in(event_we_d),
		.clear_data_in(wdata_d[3:0]),
		.flags_out(event_flags_q)
	);

	// ----------------------------------------
	// Interrupt mask and output
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			mask_q <= socket_force_pkg::MASK_RESET;
		end else if (wr_d && (offset_d == socket_force_pkg::MASK_OFFSET) && pstrb_in[0]) begin
			mask_q <= pwdata_in[3:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(event_flags_q & mask_q);
		end
	end

	// ----------------------------------------
	// Live pin status, never touched by forcing
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			live_q <= 5'h00;
		end else begin
			live_q <= {ready_pin_in, socket_powered_in, detect_b_in, detect_a_in, status_change_pin_in};
		end
	end

	// ----------------------------------------
	// Card voltage capability bits
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			volt_cap_q <= socket_force_pkg::CAP_RESET;
		end else if (trigger_d) begin
			// Fresh interrogation result replaces forced values
			volt_cap_q <= card_volt_cap_in;
		end else if (force_we_d && pstrb_in[1]) begin
			volt_cap_q <= pwdata_in[socket_force_pkg::LOWEST_VOLT_BIT:socket_force_pkg::FIVE_VOLT_BIT];
		end
	end

	// ----------------------------------------
	// Card type flags
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			wide_bus_q <= 1'b0;
			narrow_q <= 1'b0;
		end else if (trigger_d) begin
			wide_bus_q <= wide_bus_card_in;
			narrow_q <= narrow_card_in;
		end else if (force_we_d && pstrb_in[0]) begin
			wide_bus_q <= pwdata_in[socket_force_pkg::WIDE_BUS_BIT];
			narrow_q <= pwdata_in[socket_force_pkg::NARROW_BIT];
		end
	end

	// ----------------------------------------
	// Unrecognized card flag
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			unrecognized_q <= 1'b0;
		end else if (trigger_d) begin
			unrecognized_q <= unrecognized_card_in;
		end else if (force_we_d && pstrb_in[0]) begin
			unrecognized_q <= pwdata_in[socket_force_pkg::UNRECOGNIZED_BIT];
		end
	end

	// ----------------------------------------
	// Invalid supply and data loss flags
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			invalid_supply_q <= 1'b0;
		end else if (invalid_supply_set_in) begin
			invalid_supply_q <= 1'b1;
		end else if (force_we_d && pstrb_in[1]) begin
			invalid_supply_q <= pwdata_in[socket_force_pkg::INVALID_SUPPLY_BIT];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			data_loss_q <= 1'b0;
		end else if (data_loss_set_in) begin
			data_loss_q <= 1'b1;
		end else if (force_we_d && pstrb_in[1]) begin
			data_loss_q <= pwdata_in[socket_force_pkg::DATA_LOSS_BIT];
		end
	end

	// ----------------------------------------
	// Power control enable and interrogation pulse
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			power_ctrl_en_q <= socket_force_pkg::POWER_CTRL_EN_RESET;
		end else if (trigger_d) begin
			power_ctrl_en_q <= 1'b1;
		end else if (volt_forced_one_d) begin
			power_ctrl_en_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			reinterrogate_q <= 1'b0;
		end else begin
			reinterrogate_q <= trigger_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign irq_out = irq_q;
	assign power_ctrl_enable_out = power_ctrl_en_q;
	assign reinterrogate_trigger_out = reinterrogate_q;

endmodule

// file: socket_force_event_reg_monitor.sv
// Port checker for the socket force event register
`timescale 1ns/100ps
module socket_force_monitor (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic reinterrogate_trigger_out,
	input wire logic power_ctrl_enable_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	logic fw;
	logic tw;
	logic rd;
	logic unm;
	assign fw = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 32'hC && pstrb_in[1];
	assign tw = fw && pwdata_in[14];
	assign rd = pready_out && !pwrite_in;
	assign unm = paddr_in[31:8] != 24'h0 || !(paddr_in[7:0] inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
	chk_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("ready late");
	chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready too long");
	chk_trig_set: assert property (tw |=> reinterrogate_trigger_out) else $error("no trigger");
	chk_trig_cause: assert property (reinterrogate_trigger_out |-> $past(tw)) else $error("stray trigger");
	chk_cap_off: assert property (fw && !pwdata_in[14] && pwdata_in[13:10] != 4'h0 |=> !power_ctrl_enable_out)
		else $error("power control not off");
	chk_pen_on: assert property (tw |=> power_ctrl_enable_out) else $error("power control not on");
	chk_pen_hold: assert property (!$past(fw) |-> $stable(power_ctrl_enable_out))
		else $error("power control moved");
	chk_force_rd0: assert property (rd && paddr_in == 32'hC |-> prdata_out == 32'h0)
		else $error("force read not zero");
	chk_sock_caps: assert property (rd && paddr_in == 32'h8 |-> prdata_out[31:28] == 4'h3)
		else $error("socket caps wrong");
	chk_unmapped_err: assert property (pready_out && unm |-> pslverr_out)
		else $error("no error");
	chk_mapped_ok: assert property (pready_out && !unm |-> !pslverr_out)
		else $error("stray error");
	cover property (tw);
	cover property ($fell(power_ctrl_enable_out));
	cover property (pready_out && pslverr_out);
endmodule
bind socket_force_event_reg socket_force_monitor mon (
	.core_clk_in(core_clk_in),
	.srst_in(srst_in),
	.psel_in(psel_in),
	.penable_in(penable_in),
	.pwrite_in(pwrite_in),
	.paddr_in(paddr_in),
	.pwdata_in(pwdata_in),
	.pstrb_in(pstrb_in),
	.prdata_out(prdata_out),
	.pready_out(pready_out),
	.pslverr_out(pslverr_out),
	.reinterrogate_trigger_out(reinterrogate_trigger_out),
	.power_ctrl_enable_out(power_ctrl_enable_out)
);

// file: socket_card_model.sv
// Behavioural model of the card in the socket
`timescale 1ns/100ps
module socket_card_model (
	input wire logic core_clk_in,
	input wire logic [2:0] kind_in,
	output logic [3:0] card_volt_cap_out,
	output logic wide_bus_card_out,
	output logic narrow_card_out,
	output logic unrecognized_card_out,
	output logic socket_powered_out,
	output logic detect_b_out,
	output logic detect_a_out,
	output logic status_change_pin_out,
	output logic ready_pin_out
);
	logic [2:0] kind_q;
	always_ff @(posedge core_clk_in) begin
		kind_q <= kind_in;
	end
	assign card_volt_cap_out = {kind_q[1:0], kind_q[2], ~kind_q[0]};
	assign wide_bus_card_out = kind_q[0];
	assign narrow_card_out = ~kind_q[0];
	assign unrecognized_card_out = kind_q[2] & kind_q[1];
	assign socket_powered_out = kind_q[0];
	assign detect_b_out = kind_q[2];
	assign detect_a_out = 1'h0;
	assign status_change_pin_out = kind_q[1];
	assign ready_pin_out = ~kind_q[1];
endmodule

// file: tb.sv
// Self-checking bench for the socket force event register
`timescale 1ns/100ps
module tb;
	logic core_clk_in, srst_in, psel_in, penable_in, pwrite_in;
	logic [31:0] paddr_in, pwdata_in, prdata_out, d, w, r, x;
	logic [3:0] pstrb_in, card_volt_cap_in, event_set_in;
	logic pready_out, pslverr_out, wide_bus_card_in, narrow_card_in, unrecognized_card_in;
	logic invalid_supply_set_in, data_loss_set_in, socket_powered_in, detect_b_in, detect_a_in;
	logic status_change_pin_in, ready_pin_in, reinterrogate_trigger_out, power_ctrl_enable_out, irq_out;
	logic [2:0] kind;
	logic e;
	int n_mismatch, cmp_count, i, caps, inv, dl, unr, wb, nb, ev, msk;
	int seed = 50;
	int pen = 1;
	socket_force_event_reg dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.card_volt_cap_in(card_volt_cap_in), .wide_bus_card_in(wide_bus_card_in),
		.narrow_card_in(narrow_card_in), .unrecognized_card_in(unrecognized_card_in),
		.invalid_supply_set_in(invalid_supply_set_in), .data_loss_set_in(data_loss_set_in),
		.event_set_in(event_set_in), .socket_powered_in(socket_powered_in), .detect_b_in(detect_b_in),
		.detect_a_in(detect_a_in), .status_change_pin_in(status_change_pin_in), .ready_pin_in(ready_pin_in),
		.reinterrogate_trigger_out(reinterrogate_trigger_out), .power_ctrl_enable_out(power_ctrl_enable_out),
		.irq_out(irq_out));
	socket_card_model card (.core_clk_in(core_clk_in), .kind_in(kind), .card_volt_cap_out(card_volt_cap_in),
		.wide_bus_card_out(wide_bus_card_in), .narrow_card_out(narrow_card_in),
		.unrecognized_card_out(unrecognized_card_in), .socket_powered_out(socket_powered_in),
		.detect_b_out(detect_b_in), .detect_a_out(detect_a_in),
		.status_change_pin_out(status_change_pin_in), .ready_pin_out(ready_pin_in));
	initial begin
		core_clk_in = 1'h0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	task end_of_test();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] v);
		int k;
		psel_in <= 1'h1;
		penable_in <= 1'h0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= v;
		@(posedge core_clk_in);
		penable_in <= 1'h1;
		k = 0;
		do begin
			@(posedge core_clk_in);
			k++;
		end while (pready_out !== 1'h1 && k < 16);
		if (pready_out !== 1'h1) begin
			n_mismatch++;
			end_of_test();
		end
		r = prdata_out;
		e = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
		@(posedge core_clk_in);
	endtask
	task automatic chk_all();
		x = {4'h3, 14'h0, caps[3:0], inv[0], dl[0], unr[0], ready_pin_in, wb[0], nb[0], socket_powered_in,
			detect_b_in, detect_a_in, status_change_pin_in};
		xfer(1'h0, 32'h8, 32'h0);
		chk(r, x);
		xfer(1'h0, 32'h0, 32'h0);
		chk(r, ev);
		xfer(1'h0, 32'h10, 32'h0);
		chk(r, pen);
		xfer(1'h0, 32'hC, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h0);
		chk({31'h0, power_ctrl_enable_out}, pen);
		chk({31'h0, irq_out}, (ev & msk) != 0);
	endtask
	initial begin
		{srst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = {1'h1, 67'h0};
		{pstrb_in, event_set_in, invalid_supply_set_in, data_loss_set_in, kind} = {4'hF, 9'h0};
		repeat (8) @(posedge core_clk_in);
		srst_in <= 1'h0;
		@(posedge core_clk_in);
		chk_all();
		for (i = 0; i < 24; i++) begin
			kind <= 3'($random(seed));
			repeat (2) @(posedge core_clk_in);
			d = $random(seed);
			if (i < 2)
				d = i ? 32'hFFFFBFFF : 32'hFFFFFFFF;
			xfer(1'h1, 32'hC, d);
			chk({31'h0, reinterrogate_trigger_out}, {31'h0, d[14]});
			inv = int'(d[9]);
			dl = int'(d[8]);
			ev = int'(d[3:0]);
			if (d[14]) begin
				caps = int'(card_volt_cap_in);
				unr = int'(unrecognized_card_in);
				wb = int'(wide_bus_card_in);
				nb = int'(narrow_card_in);
				pen = 1;
			end else begin
				caps = int'(d[13:10]);
				unr = int'(d[7]);
				wb = int'(d[5]);
				nb = int'(d[4]);
				if (d[13:10] != 4'h0)
					pen = 0;
			end
			msk = $random(seed) & 15;
			xfer(1'h1, 32'h4, msk);
			chk_all();
			w = $random(seed);
			xfer(1'h1, 32'h0, w);
			ev = ev & ~w & 15;
			chk_all();
		end
		event_set_in <= 4'h4;
		invalid_supply_set_in <= 1'h1;
		data_loss_set_in <= 1'h1;
		@(posedge core_clk_in);
		event_set_in <= 4'h0;
		invalid_supply_set_in <= 1'h0;
		data_loss_set_in <= 1'h0;
		ev = ev | 4;
		inv = 1;
		dl = 1;
		chk_all();
		xfer(1'h0, 32'h14, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		end_of_test();
	end
endmodule
